// File: logic/gtu_params.svh
// Offsets, field positions, reset values and timing counts of the timer unit.
// Assumes one system clock and registers reached by a plain strobe port.
// What this block does
// - Five 16-bit timers, two groups, chainable.
// - Group one timers: timer, gated, counter, incremental.
// - Timer mode counts prescaled system clock.
// - Counter mode counts edges on gate/clock pin.
// - Gated mode counts while pin level enables.
// - Group one finest step is four clocks.
// - Direction by software or direction pin.
// - Incremental mode decodes quadrature into count, direction.
// - Core latch toggles on wrap, optional pin.
// - Core latch may clock both auxiliary timers.
// - Auxiliary timer as reload/capture stops counting.
// - Capture copies core timer on pin edge.
// - Reload core from auxiliary on pin/latch edge.
// - Opposite latch reloads give continuous PWM.
// - Group two finest step is two clocks.
// - Group two clocks from prescaler or pins.
// - Group two latch toggles, clocks capture timer.
// - Group two wrap clocks unit two, reloads.
// - Capture pin edge copies capture timer, optional clear.
// - Capture also from core gate/direction pins.
`ifndef GTU_PARAMS_SVH
`define GTU_PARAMS_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------------------
`define GTU_OFS_CTRL 8'h00
`define GTU_OFS_VALUE 8'h20
`define GTU_OFS_CAPTURE_RELOAD_REG 8'h40
`define GTU_OFS_G2CTRL 8'h44
`define GTU_OFS_FLAGS 8'h48

// --------------------------------------------------------------------------
// Fields of the group two control register and the capture flag bit
// --------------------------------------------------------------------------
`define GTU_G2_CAP_EDGE 1:0
`define GTU_G2_CAP_SRC 3:2
`define GTU_G2_CAP_CLEAR 4
`define GTU_G2_OVF_RELOAD 5
`define GTU_FLAG_CAPTURE 5

// --------------------------------------------------------------------------
// Reset values and timing
// --------------------------------------------------------------------------
`define GTU_CTRL_RESET 16'h0000
`define GTU_VALUE_RESET 16'h0000
`define GTU_G2CTRL_RESET 6'h00
`define GTU_G1_STEP_CYCLES 4
`define GTU_G2_STEP_CYCLES 2

`endif

// File: logic/gtu_pkg.sv
// Types shared by the timer unit: modes, configurations and pin groups.
// Assumes the parameter header is compiled alongside.
`default_nettype none

package gtu_pkg;

  // Basic count modes
  typedef enum logic [1:0] {
    GTU_MODE_TIMER = 2'b00,
    GTU_MODE_GATED = 2'b01,
    GTU_MODE_COUNTER = 2'b10,
    GTU_MODE_INCR = 2'b11
  } gtu_mode_t;

  // Auxiliary timer role toward the core timer
  typedef enum logic [1:0] {
    GTU_AUX_NORMAL = 2'b00,
    GTU_AUX_RELOAD = 2'b01,
    GTU_AUX_CAPTURE = 2'b10,
    GTU_AUX_SPARE = 2'b11
  } gtu_auxcfg_t;

  // One timer control word, bit 15 down to 0
  typedef struct packed {
    logic spare;
    logic trig_latch;
    logic clk_latch;
    logic out_en;
    gtu_auxcfg_t auxcfg;
    logic [1:0] edge_sel;
    logic dir_pin_en;
    logic down;
    logic run;
    logic [2:0] ps;
    gtu_mode_t mode;
  } gtu_ctrl_t;

  // Pin group of the five timers plus capture input
  typedef struct packed {
    logic [4:0] gc;
    logic [4:0] dir;
    logic cap;
  } gtu_pins_t;

endpackage

`default_nettype wire

// File: logic/gtu_top.sv
// Five-timer unit in two groups with toggle latches, reload and capture.
// Assumes synchronous pin inputs and a one-cycle-late register read port.
`timescale 1ns/100ps
`default_nettype none
`include "gtu_params.svh"

module gtu_top
  import gtu_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int PSW = 3
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Group one pins: aux a, core, aux b
  input wire logic AUXA_GATE_CLOCK,
  input wire logic AUXA_DIRECTION,
  input wire logic CORE_GATE_CLOCK,
  input wire logic CORE_DIRECTION,
  input wire logic AUXB_GATE_CLOCK,
  input wire logic AUXB_DIRECTION,
  // Group two pins
  input wire logic CAPT_GATE_CLOCK,
  input wire logic CAPT_DIRECTION,
  input wire logic MAIN2_GATE_CLOCK,
  input wire logic MAIN2_DIRECTION,
  input wire logic CAPTURE_INPUT,
  // Outputs
  output logic CORE_TOGGLE_OUTPUT,
  output logic GROUP_TWO_TOGGLE_OUTPUT,
  output logic UNIT_TWO_CLOCK
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Edge match: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic prev, input logic now,
                                    input logic [1:0] sel);
    edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
  endfunction

  // Prescaler tick: base step times two to the power ps
  function automatic logic pre_tick(input logic [11:0] cnt, input logic [2:0] ps,
                                    input logic [1:0] base);
    logic [11:0] mask;
    mask = 12'h000;
    mask = (12'h001 << (4'(ps) + 4'(base))) - 12'h001;
    pre_tick = ((cnt & mask) == 12'h000);
  endfunction

  // Register index of a word address
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    reg_idx = a[4:2];
  endfunction

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  localparam int NT = 5; // Timer count
  localparam int CORE = 1; // Core timer index
  localparam int CAPT = 3; // Capture timer index
  localparam int MAIN2 = 4; // Group two main timer index
  localparam logic [1:0] G1_BASE = 2'(`GTU_G1_STEP_CYCLES / 2); // Log2 of 4
  localparam logic [1:0] G2_BASE = 2'(`GTU_G2_STEP_CYCLES / 2); // Log2 of 2

  gtu_ctrl_t ctrl [NT]; // Per-timer control
  logic [WIDTH-1:0] val [NT]; // Timer counts
  logic [WIDTH-1:0] next_val [NT]; // Next counts
  logic [WIDTH-1:0] capture_reload_reg; // Capture/reload register
  logic [5:0] g2ctl; // Group two control
  logic [5:0] flags; // Sticky wrap and capture flags
  logic [11:0] pre_cnt; // Free prescaler counter
  gtu_pins_t pins; // Current pins
  gtu_pins_t pins_q; // Pins one cycle ago
  logic core_latch; // Core toggle latch
  logic core_latch_q; // Core latch one cycle ago
  logic g2_latch; // Group two toggle latch
  logic g2_latch_q; // Group two latch one cycle ago

  assign pins = '{gc: {MAIN2_GATE_CLOCK, CAPT_GATE_CLOCK, AUXB_GATE_CLOCK,
                       CORE_GATE_CLOCK, AUXA_GATE_CLOCK},
                  dir: {MAIN2_DIRECTION, CAPT_DIRECTION, AUXB_DIRECTION,
                        CORE_DIRECTION, AUXA_DIRECTION},
                  cap: CAPTURE_INPUT};

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  wire [2:0] idx = reg_idx(ADDR); // Word index inside a bank
  wire idx_ok = (idx < 3'(NT)); // Timer index in range
  wire hit_ctrl = (ADDR[7:5] == `GTU_OFS_CTRL >> 5) && idx_ok && ADDR[1:0] == 2'b00;
  wire hit_val = (ADDR[7:5] == `GTU_OFS_VALUE >> 5) && idx_ok && ADDR[1:0] == 2'b00;
  wire hit_cr = (ADDR == `GTU_OFS_CAPTURE_RELOAD_REG);
  wire hit_g2 = (ADDR == `GTU_OFS_G2CTRL);
  wire hit_fl = (ADDR == `GTU_OFS_FLAGS);
  wire [15:0] rd_mux = hit_ctrl ? ctrl[idx] :
                       hit_val ? val[idx] :
                       hit_cr ? capture_reload_reg :
                       hit_g2 ? {10'h000, g2ctl} :
                       hit_fl ? {10'h000, flags} : 16'h0000; // Unmapped reads zero

  // --------------------------------------------------------------------------
  // Per-timer count enable and direction
  // --------------------------------------------------------------------------
  logic [NT-1:0] cnt_en; // Count step this cycle
  logic [NT-1:0] down_now; // Effective direction, 1 is down
  logic [NT-1:0] wrap; // Overflow or underflow this cycle

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      wire is_g1 = (g < 3); // Group one timer
      wire [1:0] base = is_g1 ? G1_BASE : G2_BASE;
      wire tick = pre_tick(pre_cnt, ctrl[g].ps, base);
      wire latch_now = (g == CAPT) ? g2_latch : core_latch; // Chained source
      wire latch_old = (g == CAPT) ? g2_latch_q : core_latch_q;
      wire chain_ok = (g == 0) || (g == 2) || (g == CAPT); // Latch-clockable
      wire use_latch = chain_ok && ctrl[g].clk_latch;
      wire src_now = use_latch ? latch_now : pins.gc[g];
      wire src_old = use_latch ? latch_old : pins_q.gc[g];
      wire ext_ev = edge_hit(src_old, src_now, ctrl[g].edge_sel);
      wire gate_on = (pins.gc[g] == ctrl[g].edge_sel[0]);
      wire qa_chg = pins.gc[g] ^ pins_q.gc[g]; // Encoder A moved
      wire qb_chg = pins.dir[g] ^ pins_q.dir[g]; // Encoder B moved
      wire q_up = pins.gc[g] ^ pins_q.dir[g]; // A leads B counts up
      wire is_aux = (g == 0) || (g == 2);
      wire parked = is_aux && ctrl[g].auxcfg != GTU_AUX_NORMAL;
      wire incr = is_g1 && ctrl[g].mode == GTU_MODE_INCR;
      wire pin_dir = ctrl[g].dir_pin_en ? pins.dir[g] ^ ctrl[g].down : ctrl[g].down;
      logic step;
      always_comb begin
        unique case (ctrl[g].mode)
          GTU_MODE_TIMER: step = tick;
          GTU_MODE_GATED: step = tick & gate_on;
          GTU_MODE_COUNTER: step = ext_ev;
          GTU_MODE_INCR: step = is_g1 & (qa_chg | qb_chg);
        endcase
      end
      assign cnt_en[g] = ctrl[g].run & ~parked & step;
      assign down_now[g] = incr ? (~q_up ^ ctrl[g].down) : pin_dir;
      assign wrap[g] = cnt_en[g] & (down_now[g] ? val[g] == '0 : val[g] == '1);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Reload and capture triggers
  // --------------------------------------------------------------------------
  // Aux trigger: pin edge, or core latch edge for reload
  function automatic logic aux_trig(input gtu_ctrl_t c, input logic p_old,
                                    input logic p_now, input logic l_old,
                                    input logic l_now);
    aux_trig = c.trig_latch ? edge_hit(l_old, l_now, c.edge_sel)
                            : edge_hit(p_old, p_now, c.edge_sel);
  endfunction

  wire trig_a = aux_trig(ctrl[0], pins_q.gc[0], pins.gc[0], core_latch_q, core_latch);
  wire trig_b = aux_trig(ctrl[2], pins_q.gc[2], pins.gc[2], core_latch_q, core_latch);
  wire rel_a = trig_a && ctrl[0].auxcfg == GTU_AUX_RELOAD;
  wire rel_b = trig_b && ctrl[2].auxcfg == GTU_AUX_RELOAD;
  wire cap_a = trig_a && !ctrl[0].trig_latch && ctrl[0].auxcfg == GTU_AUX_CAPTURE;
  wire cap_b = trig_b && !ctrl[2].trig_latch && ctrl[2].auxcfg == GTU_AUX_CAPTURE;

  // Group two capture source select
  wire [1:0] cap_src = g2ctl[`GTU_G2_CAP_SRC];
  wire [1:0] cap_edge = g2ctl[`GTU_G2_CAP_EDGE];
  wire cap_pin_ev = edge_hit(pins_q.cap, pins.cap, cap_edge);
  wire cap_gc_ev = edge_hit(pins_q.gc[CORE], pins.gc[CORE], cap_edge);
  wire cap_dir_ev = edge_hit(pins_q.dir[CORE], pins.dir[CORE], cap_edge);
  wire g2_cap = (cap_src == 2'b00) ? cap_pin_ev :
                (cap_src == 2'b01) ? cap_gc_ev :
                (cap_src == 2'b10) ? cap_dir_ev : (cap_gc_ev | cap_dir_ev);
  wire main2_reload = wrap[MAIN2] & g2ctl[`GTU_G2_OVF_RELOAD];

  // Software writes
  wire wr_ctrl = WR & hit_ctrl;
  wire wr_val = WR & hit_val;
  wire wr_cr = WR & hit_cr;
  wire wr_g2 = WR & hit_g2;
  wire wr_fl = WR & hit_fl;

  // Flag update: hardware set wins over write-one clear
  wire [5:0] flag_set = {g2_cap, wrap};
  wire [5:0] next_flags = (flags & ~(wr_fl ? WDATA[5:0] : 6'h00)) | flag_set;

  // --------------------------------------------------------------------------
  // Next timer values
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      // Plain count, wraps at the 16-bit limit
      if (cnt_en[i]) begin
        next_val[i] = down_now[i] ? val[i] - WIDTH'(1) : val[i] + WIDTH'(1);
      end else begin
        next_val[i] = val[i];
      end
    end
    // Core reload from an auxiliary timer
    if (rel_a) begin
      next_val[CORE] = val[0];
    end else if (rel_b) begin
      next_val[CORE] = val[2];
    end
    // Auxiliary capture of the core count
    if (cap_a) begin
      next_val[0] = val[CORE];
    end
    if (cap_b) begin
      next_val[2] = val[CORE];
    end
    // Capture timer optional clear after capture
    if (g2_cap && g2ctl[`GTU_G2_CAP_CLEAR]) begin
      next_val[CAPT] = '0;
    end
    // Group two main timer reload on wrap
    if (main2_reload) begin
      next_val[MAIN2] = capture_reload_reg;
    end
    // Software write takes precedence
    if (wr_val) begin
      next_val[idx] = WDATA;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------

  // Timer counts and controls
  always_ff @(posedge MCLK) begin
    for (int i = 0; i < NT; i++) begin
      if (RST) begin
        val[i] <= `GTU_VALUE_RESET;
        ctrl[i] <= `GTU_CTRL_RESET;
      end else begin
        val[i] <= next_val[i];
        if (wr_ctrl && idx == 3'(i)) begin
          ctrl[i] <= WDATA;
        end
      end
    end
  end

  // Capture/reload register and group two control
  always_ff @(posedge MCLK) begin
    if (RST) begin
      capture_reload_reg <= `GTU_VALUE_RESET;
      g2ctl <= `GTU_G2CTRL_RESET;
    end else begin
      if (g2_cap) begin
        capture_reload_reg <= val[CAPT];
      end else if (wr_cr) begin
        capture_reload_reg <= WDATA;
      end
      if (wr_g2) begin
        g2ctl <= WDATA[5:0];
      end
    end
  end

  // Prescaler, pin history and flags
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pre_cnt <= 12'h000;
      pins_q <= '0;
      flags <= 6'h00;
    end else begin
      pre_cnt <= pre_cnt + 12'h001;
      pins_q <= pins;
      flags <= next_flags;
    end
  end

  // Toggle latches and their history
  always_ff @(posedge MCLK) begin
    if (RST) begin
      core_latch <= 1'b0;
      core_latch_q <= 1'b0;
      g2_latch <= 1'b0;
      g2_latch_q <= 1'b0;
    end else begin
      core_latch <= core_latch ^ wrap[CORE];
      core_latch_q <= core_latch;
      g2_latch <= g2_latch ^ wrap[MAIN2];
      g2_latch_q <= g2_latch;
    end
  end

  // Outputs, each from a flip-flop
  always_ff @(posedge MCLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
      CORE_TOGGLE_OUTPUT <= 1'b0;
      GROUP_TWO_TOGGLE_OUTPUT <= 1'b0;
      UNIT_TWO_CLOCK <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
      CORE_TOGGLE_OUTPUT <= ctrl[CORE].out_en & (core_latch ^ wrap[CORE]);
      GROUP_TWO_TOGGLE_OUTPUT <= ctrl[MAIN2].out_en & (g2_latch ^ wrap[MAIN2]);
      UNIT_TWO_CLOCK <= wrap[MAIN2];
    end
  end

endmodule

`default_nettype wire

// File: sim/gtu_top_properties.sv
// Checker for the timer unit: register port and output timing.
// Assumes it is bound onto gtu_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module gtu_top_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Outputs
  input wire logic CORE_TOGGLE_OUTPUT,
  input wire logic GROUP_TWO_TOGGLE_OUTPUT,
  input wire logic UNIT_TWO_CLOCK
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // -------------------------------------------------------------------
  // Sequences
  // -------------------------------------------------------------------
  // Write then read of one register, no gap
  sequence s_echo(a);
    WR && ADDR == a ##1 RD && ADDR == a;
  endsequence
  // Core latch output flip not caused by a write two edges back
  sequence s_core_flip;
    $changed(CORE_TOGGLE_OUTPUT) && !$past(WR, 2);
  endsequence
  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data without a read");
  a_unmapped_read: assert property (RD && ADDR == 8'h80 |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(RST) |-> RDATA == 16'h0000 &&
    !CORE_TOGGLE_OUTPUT && !GROUP_TWO_TOGGLE_OUTPUT && !UNIT_TWO_CLOCK)
    else $error("outputs not quiet after reset");
  a_u2clk_pulse: assert property (UNIT_TWO_CLOCK |=> !UNIT_TWO_CLOCK)
    else $error("unit two clock wider than one cycle");
  a_g2_wrap_link: assert property ($changed(GROUP_TWO_TOGGLE_OUTPUT) && !$past(WR, 2)
    |-> ##[0:1] UNIT_TWO_CLOCK)
    else $error("group two latch moved without a wrap");
  a_core_spacing: assert property (s_core_flip
    |=> (!$changed(CORE_TOGGLE_OUTPUT) || $past(WR, 2)) [*3])
    else $error("core latch flips too close");
  a_ctrl_echo: assert property (s_echo(8'h04) |=> RDATA[14:0] == $past(WDATA[14:0], 2))
    else $error("core control readback wrong");
  a_g2ctrl_echo: assert property (s_echo(8'h44) |=> RDATA[5:0] == $past(WDATA[5:0], 2))
    else $error("group two control readback wrong");
endmodule
bind gtu_top gtu_top_checker gtu_top_checker_i (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CORE_TOGGLE_OUTPUT(CORE_TOGGLE_OUTPUT),
  .GROUP_TWO_TOGGLE_OUTPUT(GROUP_TWO_TOGGLE_OUTPUT), .UNIT_TWO_CLOCK(UNIT_TWO_CLOCK));
`default_nettype wire

// File: sim/gtu_pin_model.sv
// Pin-side model: encoder, gate, count, direction and capture pins.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/100ps
`default_nettype none
module gtu_pin_model
  import gtu_pkg::*;
(
  // Clock and encoder control
  input wire logic MCLK,
  input wire logic quad_en,
  input wire logic quad_rev,
  // Pins toward the unit
  output var gtu_pins_t pins
);
  logic [1:0] phase; // Encoder position
  logic [2:0] div; // Eight cycles a step
  wire [1:0] next_phase = quad_rev ? phase - 2'h1 : phase + 2'h1;
  initial begin
    pins = '0;
    phase = 2'h0;
    div = 3'h0;
  end
  // Gray-coded tracks A and B only; index stays with the system
  always @(posedge MCLK) begin
    if (quad_en) begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
        phase <= next_phase;
        pins.gc[1] <= next_phase[1];
        pins.dir[1] <= next_phase[1] ^ next_phase[0];
      end
    end
  end
  // Set one pin after an edge; index 5 is the capture input
  task automatic set(input bit d, input int idx, input logic v);
    @(posedge MCLK);
    if (idx == 5) pins.cap <= v;
    else if (d) pins.dir[idx] <= v;
    else pins.gc[idx] <= v;
  endtask
  // Rising edges four cycles high, four low
  task automatic pulses(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      set(1'b0, idx, 1'b1);
      repeat (3) @(posedge MCLK);
      set(1'b0, idx, 1'b0);
      repeat (3) @(posedge MCLK);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/gtu_top_tb.sv
// Self-checking bench for the five-timer unit.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module gtu_top_tb
  import gtu_pkg::*;
;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic quad_en = 1'b0;
  logic quad_rev = 1'b0;
  logic [15:0] RDATA;
  logic core_out;
  logic g2_out;
  logic u2clk;
  gtu_pins_t pins;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int u2_pulses = 0;
  logic [15:0] q;
  logic [15:0] q2;
  gtu_top gtu_top_i (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .AUXA_GATE_CLOCK(pins.gc[0]), .AUXA_DIRECTION(pins.dir[0]),
    .CORE_GATE_CLOCK(pins.gc[1]), .CORE_DIRECTION(pins.dir[1]),
    .AUXB_GATE_CLOCK(pins.gc[2]), .AUXB_DIRECTION(pins.dir[2]),
    .CAPT_GATE_CLOCK(pins.gc[3]), .CAPT_DIRECTION(pins.dir[3]),
    .MAIN2_GATE_CLOCK(pins.gc[4]), .MAIN2_DIRECTION(pins.dir[4]), .CAPTURE_INPUT(pins.cap),
    .CORE_TOGGLE_OUTPUT(core_out), .GROUP_TWO_TOGGLE_OUTPUT(g2_out), .UNIT_TWO_CLOCK(u2clk));
  gtu_pin_model gtu_pin_model_i (.MCLK(MCLK), .quad_en(quad_en), .quad_rev(quad_rev),
    .pins(pins));
  initial forever #2 MCLK = ~MCLK;
  // Pulse count and hang guard, off the sampling edge
  always @(negedge MCLK) begin
    cycles++;
    if (u2clk === 1'b1) u2_pulses++;
    if (cycles == 20000) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end
  // -------------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // Write, then read the same place with no gap
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] v);
    wr(a, d);
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), q);
      chk(q, 16'h0000, 16'h0000);
      rd(8'(8'h20 + 4 * i), q);
      chk(q, 16'h0000, 16'h0000);
    end
    wr(8'h80, 16'hffff);
    rd(8'h80, q);
    chk(q, 16'h0000, 16'h0000);
    wrrd(8'h04, 16'h0040, q);
    chk(q, 16'h0040, 16'h0040);
    wrrd(8'h44, 16'h002a, q);
    chk(q, 16'h002a, 16'h002a);
    wr(8'h44, 16'h0000);
    wr(8'h04, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_timer;
    for (int ps = 0; ps < 3; ps++) begin
      wr(8'h20, 16'h0000);
      wr(8'h00, 16'(16'h0020 | (ps << 2)));
      repeat (256) @(posedge MCLK);
      wr(8'h00, 16'h0000);
      rd(8'h20, q);
      chk(q, 16'((64 >> ps) - 1), 16'((64 >> ps) + 2));
    end
    wr(8'h24, 16'hfff0);
    wr(8'h04, 16'h1020);
    repeat (80) @(posedge MCLK);
    rd(8'h24, q);
    chk(q, 16'h0002, 16'h0006);
    chk({15'h0, core_out}, 16'h0001, 16'h0001);
    rd(8'h48, q);
    chk(q & 16'h0002, 16'h0002, 16'h0002);
    wr(8'h48, 16'h0002);
    rd(8'h48, q);
    chk(q & 16'h0002, 16'h0000, 16'h0000);
    wr(8'h04, 16'h1060);
    repeat (40) @(posedge MCLK);
    rd(8'h24, q);
    chk(q, 16'hfff5, 16'hffff);
    chk({15'h0, core_out}, 16'h0000, 16'h0000);
    wr(8'h04, 16'h0000);
    $display("test timer done");
  endtask
  task automatic t_modes;
    wr(8'h28, 16'h0000);
    wr(8'h08, 16'h0121);
    repeat (40) @(posedge MCLK);
    rd(8'h28, q);
    chk(q, 16'h0000, 16'h0000);
    gtu_pin_model_i.set(1'b0, 2, 1'b1);
    repeat (80) @(posedge MCLK);
    gtu_pin_model_i.set(1'b0, 2, 1'b0);
    rd(8'h28, q);
    chk(q, 16'd19, 16'd22);
    rd(8'h28, q2);
    chk(q2, q, q);
    wr(8'h08, 16'h0000);
    wr(8'h20, 16'h0000);
    wr(8'h00, 16'h0122);
    gtu_pin_model_i.pulses(0, 5);
    rd(8'h20, q);
    chk(q, 16'd5, 16'd5);
    wr(8'h00, 16'h01a2);
    gtu_pin_model_i.set(1'b1, 0, 1'b1);
    gtu_pin_model_i.pulses(0, 3);
    rd(8'h20, q);
    chk(q, 16'd2, 16'd2);
    wr(8'h00, 16'h0000);
    gtu_pin_model_i.set(1'b1, 0, 1'b0);
    $display("test modes done");
  endtask
  task automatic t_quad;
    wr(8'h24, 16'h8000);
    wr(8'h04, 16'h0023);
    wr(8'h48, 16'h0020);
    wr(8'h44, 16'h0007);
    for (int r = 0; r < 2; r++) begin
      @(posedge MCLK);
      quad_rev <= r[0];
      quad_en <= 1'b1;
      repeat (128) @(posedge MCLK);
      quad_en <= 1'b0;
      rd(8'h24, q);
      if (r == 0) chk(q > 16'h8000 ? q - 16'h8000 : 16'h8000 - q, 16'd4, 16'd16);
    end
    chk(q, 16'h8000, 16'h8000);
    rd(8'h48, q);
    chk(q & 16'h0020, 16'h0020, 16'h0020);
    wr(8'h04, 16'h0000);
    wr(8'h44, 16'h0000);
    $display("test encoder done");
  endtask
  task automatic t_capture;
    wr(8'h24, 16'h1234);
    wr(8'h00, 16'h0920);
    gtu_pin_model_i.pulses(0, 1);
    rd(8'h20, q);
    chk(q, 16'h1234, 16'h1234);
    repeat (40) @(posedge MCLK);
    rd(8'h20, q);
    chk(q, 16'h1234, 16'h1234);
    wr(8'h28, 16'h4321);
    wr(8'h08, 16'h0520);
    gtu_pin_model_i.pulses(2, 1);
    rd(8'h24, q);
    chk(q, 16'h4321, 16'h4321);
    rd(8'h28, q);
    chk(q, 16'h4321, 16'h4321);
    wr(8'h00, 16'h0000);
    wr(8'h08, 16'h0000);
    $display("test capture done");
  endtask
  task automatic t_group_two;
    wr(8'h2c, 16'hfffc);
    wr(8'h48, 16'h0020);
    wr(8'h44, 16'h0011);
    gtu_pin_model_i.pulses(5, 1);
    rd(8'h40, q);
    chk(q, 16'hfffc, 16'hfffc);
    rd(8'h2c, q);
    chk(q, 16'h0000, 16'h0000);
    rd(8'h48, q);
    chk(q & 16'h0020, 16'h0020, 16'h0020);
    wr(8'h44, 16'h0020);
    wr(8'h30, 16'hfffc);
    u2_pulses = 0;
    wr(8'h10, 16'h1020);
    repeat (80) @(posedge MCLK);
    wr(8'h10, 16'h1000);
    rd(8'h30, q);
    chk(16'(u2_pulses), 16'd9, 16'd12);
    chk({15'h0, g2_out}, 16'(u2_pulses % 2), 16'(u2_pulses % 2));
    $display("test group two done");
  endtask
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    t_regs();
    t_timer();
    t_modes();
    t_quad();
    t_capture();
    t_group_two();
    report_and_stop();
  end
endmodule
`default_nettype wire
